// ### hw/seq_ctrl_device.sv
// Overview of operation
// RULE1 - Order register select is 0010, bit15 low
// RULE2 - Host writes zero to order bit 10
// RULE3 - Loop bit repeats sequence, resets low
// RULE4 - Temperature bit adds die reading
// RULE5 - Channel bits 7..0 include inputs
// RULE6 - General register select is 0011, bit15 low
// RULE7 - Charge mode powers buffer only converting
// RULE8 - Charge mode clear keeps buffer powered
// RULE9 - Bit 8 enables input buffer
// RULE10 - Freeze bit blocks pin setup writes
// RULE11 - Broadcast bit loads every DAC channel; code loads only the channels set in the DAC pin setup
// RULE12 - Otherwise address picks single DAC
// RULE13 - Bit 5 doubles input span
// RULE14 - Bit 4 doubles output span
// RULE15 - Host writes zero to bits 3..0
// RULE16 - DAC write: bit15 set, address 14..12
// RULE17 - Update only addressed register bits 10..0
`timescale 1ns/10ps
module seq_ctrl_device
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   seq_ctrl_if.device       link,
   input  wire logic        i_converting,
   output logic [7:0]       o_channel_list,
   output logic             o_temp_sample,
   output logic             o_loop_sequence,
   output logic             o_buffer_power,
   output logic             o_input_span,
   output logic             o_output_span,
   output logic             o_pin_setup_freeze,
   output logic [7:0]       o_adc_pins,
   output logic [7:0]       o_dac_pins,
   output logic [7:0]       o_dac_load,
   output logic [11:0]      o_dac_data
);
   logic        cap_strobe;
   logic [15:0] cap_word;
   logic [10:0] order_r;
   logic [10:0] order_nxt;
   logic [10:0] general_r;
   logic [10:0] general_nxt;
   logic [7:0]  adc_pins_r;
   logic [7:0]  adc_pins_nxt;
   logic [7:0]  dac_pins_r;
   logic [7:0]  dac_pins_nxt;
   logic [7:0]  load_r;
   logic [7:0]  load_nxt;
   logic [11:0] dac_data_r;
   logic [11:0] dac_data_nxt;
   logic        buf_r;
   logic        buf_nxt;
   logic [3:0]  sel;
   logic [2:0]  dac_ch;
   logic        dac_write;
   logic        cfg_write;

   cmd_word_capture u_capture
   (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_valid  (link.word_valid),
      .i_word   (link.word),
      .o_strobe (cap_strobe),
      .o_word   (cap_word)
   );

   assign sel    = cap_word[seq_ctrl_pkg::SEL_HI:seq_ctrl_pkg::SEL_LO];
   assign dac_ch = cap_word[seq_ctrl_pkg::DAC_CH_HI:seq_ctrl_pkg::DAC_CH_LO];
   assign dac_write = cap_strobe && cap_word[seq_ctrl_pkg::CMD_BIT];
   assign cfg_write = cap_strobe && !cap_word[seq_ctrl_pkg::CMD_BIT];

   // ************************************************************
   // Sequence and general control registers
   // ************************************************************
   always_comb
   begin
      order_nxt   = order_r;
      general_nxt = general_r;
      if (cfg_write)
      begin
         case (sel)
            seq_ctrl_pkg::SEL_ORDER:   order_nxt   = cap_word[10:0];   // [RULE17] [RULE1]
            seq_ctrl_pkg::SEL_GENERAL: general_nxt = cap_word[10:0];   // [RULE17] [RULE6]
            default:                   order_nxt   = order_r;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         order_r   <= seq_ctrl_pkg::RESET_VAL;                     // [RULE3] [RULE5]
         general_r <= seq_ctrl_pkg::RESET_VAL;                     // [RULE9]
      end
      else
      begin
         order_r   <= order_nxt;
         general_r <= general_nxt;
      end
   end

   // ************************************************************
   // Pin setup registers
   // ************************************************************
   always_comb
   begin
      adc_pins_nxt = adc_pins_r;
      dac_pins_nxt = dac_pins_r;
      // Frozen setup drops writes silently; host reads return the sent word, only o_adc_pins and o_dac_pins show it
      if (cfg_write && !general_r[seq_ctrl_pkg::FREEZE_BIT])
      begin
         if (sel == seq_ctrl_pkg::SEL_ADC_PINS)
            adc_pins_nxt = cap_word[7:0];                          // [RULE10]
         if (sel == seq_ctrl_pkg::SEL_DAC_PINS)
            dac_pins_nxt = cap_word[7:0];                          // [RULE10]
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         adc_pins_r <= 8'h00;
         dac_pins_r <= 8'h00;
      end
      else
      begin
         adc_pins_r <= adc_pins_nxt;
         dac_pins_r <= dac_pins_nxt;
      end
   end

   // ************************************************************
   // DAC write strobes and data
   // ************************************************************
   // One decoder per channel; broadcast follows the DAC pin setup
   for (genvar ch = 0; ch < 8; ch = ch + 1)
   begin : g_load
      always_comb
      begin
         load_nxt[ch] = 1'b0;
         if (dac_write)
         begin
            if (general_r[seq_ctrl_pkg::BCAST_BIT])
               load_nxt[ch] = dac_pins_r[ch];                      // [RULE11] [RULE16]
            else
               load_nxt[ch] = (dac_ch == 3'(ch));                  // [RULE12] [RULE16]
         end
      end
   end

   always_comb
   begin
      dac_data_nxt = dac_data_r;
      if (dac_write)
         dac_data_nxt = cap_word[11:0];                            // [RULE16]
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         load_r     <= 8'h00;
         dac_data_r <= 12'h000;
      end
      else
      begin
         load_r     <= load_nxt;
         dac_data_r <= dac_data_nxt;
      end
   end

   // ************************************************************
   // Input buffer power
   // ************************************************************
   // Charge mode gates power to conversion time only
   always_comb
   begin
      if (!general_r[seq_ctrl_pkg::BUF_ON_BIT])
         buf_nxt = 1'b0;                                           // [RULE9]
      else if (general_r[seq_ctrl_pkg::CHARGE_BIT])
         buf_nxt = i_converting;                                   // [RULE7]
      else
         buf_nxt = 1'b1;                                           // [RULE8]
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         buf_r <= 1'b0;
      else
         buf_r <= buf_nxt;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_channel_list     = order_r[7:0];                                  // [RULE5]
   assign o_temp_sample      = order_r[seq_ctrl_pkg::TEMP_BIT];               // [RULE4]
   assign o_loop_sequence    = order_r[seq_ctrl_pkg::LOOP_BIT];               // [RULE3]
   assign o_buffer_power     = buf_r;
   assign o_input_span       = general_r[seq_ctrl_pkg::IN_SPAN_BIT];          // [RULE13]
   assign o_output_span      = general_r[seq_ctrl_pkg::OUT_SPAN_BIT];         // [RULE14]
   assign o_pin_setup_freeze = general_r[seq_ctrl_pkg::FREEZE_BIT];
   assign o_adc_pins         = adc_pins_r;
   assign o_dac_pins         = dac_pins_r;
   assign o_dac_load         = load_r;
   assign o_dac_data         = dac_data_r;
endmodule : seq_ctrl_device

// ### hw/seq_ctrl_pkg.sv
package seq_ctrl_pkg;
   // ************************************************************
   // Command word layout
   // ************************************************************
   localparam int          WORD_W        = 16;
   localparam int          CMD_BIT       = 15;
   localparam int          SEL_HI        = 14;
   localparam int          SEL_LO        = 11;
   localparam int          DATA_HI       = 10;
   localparam int          DAC_CH_HI     = 14;
   localparam int          DAC_CH_LO     = 12;
   localparam logic [3:0]  SEL_NOP       = 4'h0;
   localparam logic [3:0]  SEL_ORDER     = 4'h2;
   localparam logic [3:0]  SEL_GENERAL   = 4'h3;
   localparam logic [3:0]  SEL_ADC_PINS  = 4'h4;
   localparam logic [3:0]  SEL_DAC_PINS  = 4'h5;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int          LOOP_BIT      = 9;
   localparam int          TEMP_BIT      = 8;
   localparam int          CHARGE_BIT    = 9;
   localparam int          BUF_ON_BIT    = 8;
   localparam int          FREEZE_BIT    = 7;
   localparam int          BCAST_BIT     = 6;
   localparam int          IN_SPAN_BIT   = 5;
   localparam int          OUT_SPAN_BIT  = 4;
   localparam logic [10:0] RESET_VAL     = 11'h000;
   // ************************************************************
   // Host register map (Avalon word offsets)
   // ************************************************************
   localparam logic [1:0]  HOFS_CMD      = 2'h0;
   localparam logic [1:0]  HOFS_STATUS   = 2'h1;
   localparam logic [1:0]  HOFS_LAST     = 2'h2;
   localparam int          BITS_PER_WORD = 16;
endpackage : seq_ctrl_pkg

// ### hw/seq_ctrl_if.sv
`timescale 1ns/10ps
interface seq_ctrl_if;
   logic        word_valid;
   logic [15:0] word;
   modport host   (output word_valid, output word);
   modport device (input word_valid, input word);
endinterface : seq_ctrl_if

// ### hw/cmd_word_capture.sv
`timescale 1ns/10ps
module cmd_word_capture
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_valid,
   input  wire logic [15:0] i_word,
   output logic             o_strobe,
   output logic [15:0]      o_word
);
   logic        strobe_r;
   logic        strobe_nxt;
   logic [15:0] word_r;
   logic [15:0] word_nxt;

   always_comb
   begin
      strobe_nxt = i_valid;
      word_nxt   = i_valid ? i_word : word_r;
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         strobe_r <= 1'b0;
         word_r   <= 16'h0000;
      end
      else
      begin
         strobe_r <= strobe_nxt;
         word_r   <= word_nxt;
      end
   end

   assign o_strobe = strobe_r;
   assign o_word   = word_r;
endmodule : cmd_word_capture

// ### hw/seq_ctrl_host.sv
`timescale 1ns/10ps
module seq_ctrl_host
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   seq_ctrl_if.host         link,
   input  wire logic [1:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest
);
   logic        valid_r;
   logic        valid_nxt;
   logic [15:0] word_r;
   logic [15:0] word_nxt;
   logic [15:0] last_r;
   logic [15:0] last_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic [15:0] w;

   // Reserved bits forced low so software slips cannot reach the device
   always_comb
   begin
      w = i_avs_writedata[15:0];
      if (!w[seq_ctrl_pkg::CMD_BIT] && w[14:11] == seq_ctrl_pkg::SEL_ORDER)
         w[10] = 1'b0;                                             // [RULE2] [RULE1]
      if (!w[seq_ctrl_pkg::CMD_BIT] && w[14:11] == seq_ctrl_pkg::SEL_GENERAL)
      begin
         w[10]  = 1'b0;
         w[3:0] = 4'h0;                                            // [RULE15] [RULE6]
      end
   end

   // ************************************************************
   // Avalon slave, one wait state per access
   // ************************************************************
   always_comb
   begin
      valid_nxt = 1'b0;
      word_nxt  = word_r;
      last_nxt  = last_r;
      rdata_nxt = rdata_r;
      ack_nxt   = 1'b0;
      if ((i_avs_read || i_avs_write) && !ack_r)
      begin
         ack_nxt = 1'b1;
         if (i_avs_write && i_avs_address == seq_ctrl_pkg::HOFS_CMD)
         begin
            valid_nxt = 1'b1;                                      // [RULE16]
            word_nxt  = w;
            last_nxt  = w;
         end
         case (i_avs_address)
            seq_ctrl_pkg::HOFS_CMD:    rdata_nxt = {16'h0000, word_r};
            seq_ctrl_pkg::HOFS_STATUS: rdata_nxt = {{31{1'b0}}, valid_r};
            seq_ctrl_pkg::HOFS_LAST:   rdata_nxt = {16'h0000, last_r};
            default:                   rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         valid_r <= 1'b0;
         word_r  <= 16'h0000;
         last_r  <= 16'h0000;
         rdata_r <= 32'h00000000;
         ack_r   <= 1'b0;
      end
      else
      begin
         valid_r <= valid_nxt;
         word_r  <= word_nxt;
         last_r  <= last_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   assign link.word_valid   = valid_r;
   assign link.word         = word_r;
   assign o_avs_readdata    = rdata_r;
   assign o_avs_waitrequest = !ack_r;
endmodule : seq_ctrl_host

// ### verif/seq_ctrl_props.sv
`timescale 1ns/10ps
module seq_ctrl_props
(
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        word_valid,
   input wire logic [15:0] word,
   input wire logic        i_converting,
   input wire logic [7:0]  o_channel_list,
   input wire logic        o_temp_sample,
   input wire logic        o_loop_sequence,
   input wire logic        o_buffer_power,
   input wire logic        o_input_span,
   input wire logic        o_output_span,
   input wire logic        o_pin_setup_freeze,
   input wire logic [7:0]  o_adc_pins,
   input wire logic [7:0]  o_dac_pins,
   input wire logic [7:0]  o_dac_load,
   input wire logic [11:0] o_dac_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   logic       ord;
   logic       gen;
   logic       dac;
   logic       bc_r;
   logic       bc_nxt;
   logic [7:0] exp_load;
   assign ord = word_valid && word[15:11] == 5'h02;
   assign gen = word_valid && word[15:11] == 5'h03;
   assign dac = word_valid && word[15];
   // Broadcast mode as last sent on the link
   always_comb bc_nxt = gen ? word[6] : bc_r;
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst) bc_r <= 1'b0;
      else bc_r <= bc_nxt;
   assign exp_load = bc_r ? o_dac_pins : 8'h01 << word[14:12];
   chk_order_fields : assert property (ord |-> ##2
      {o_loop_sequence, o_temp_sample, o_channel_list} == $past(word[9:0], 2)) else $error("order fields wrong");
   chk_gen_fields : assert property (gen |-> ##2
      {o_pin_setup_freeze, o_input_span, o_output_span} == {$past(word[7], 2), $past(word[5:4], 2)})
      else $error("general fields wrong");
   chk_buf_power : assert property (gen |-> ##3 o_buffer_power ==
      ($past(word[8], 3) && (!$past(word[9], 3) || $past(i_converting)))) else $error("buffer power wrong");
   chk_reserved_zero : assert property ((ord || gen) |-> !word[10] && (ord || word[3:0] == 4'h0))
      else $error("reserved bits sent");
   chk_pin_freeze : assert property (word_valid && word[15:11] == 5'h04 |-> ##2 o_adc_pins ==
      ($past(o_pin_setup_freeze, 2) ? $past(o_adc_pins, 2) : $past(word[7:0], 2))) else $error("pin setup wrong");
   chk_dac_target : assert property (dac |-> ##2 o_dac_load == $past(exp_load, 2))
      else $error("dac target wrong");
   chk_dac_data : assert property (dac |-> ##2 o_dac_data == $past(word[11:0], 2))
      else $error("dac data wrong");
   chk_load_cause : assert property (o_dac_load != 8'h00 |-> $past(dac, 2)) else $error("stray dac load");
   chk_valid_pulse : assert property (word_valid |=> !word_valid) else $error("word valid too long");
   cover property (ord);
   cover property (dac && bc_r);
   cover property (gen && word[9] && word[8]);
   cover property (word_valid && word[15:11] == 5'h04 && o_pin_setup_freeze);
endmodule : seq_ctrl_props

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_converting = 1'b0;
   logic [1:0]  i_avs_address = 2'h0;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata, q;
   logic        o_avs_waitrequest, o_temp_sample, o_loop_sequence, o_buffer_power;
   logic        o_input_span, o_output_span, o_pin_setup_freeze;
   logic [7:0]  o_channel_list, o_adc_pins, o_dac_pins, o_dac_load, e_adc, e_dac;
   logic [11:0] o_dac_data;
   logic [10:0] e_ord, e_gen;
   logic [15:0] rnd = 16'h0010;
   logic [15:0] w;
   int          mismatches = 0;
   int          n_checks = 0;
   always #12.5 i_clk = ~i_clk;
   seq_ctrl_if u_seq_ctrl_if ();
   seq_ctrl_host u_seq_ctrl_host (.i_clk(i_clk), .i_nrst(i_nrst), .link(u_seq_ctrl_if), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
   seq_ctrl_device u_seq_ctrl_device (.i_clk(i_clk), .i_nrst(i_nrst), .link(u_seq_ctrl_if), .i_converting(i_converting),
      .o_channel_list(o_channel_list), .o_temp_sample(o_temp_sample), .o_loop_sequence(o_loop_sequence),
      .o_buffer_power(o_buffer_power), .o_input_span(o_input_span), .o_output_span(o_output_span),
      .o_pin_setup_freeze(o_pin_setup_freeze), .o_adc_pins(o_adc_pins), .o_dac_pins(o_dac_pins),
      .o_dac_load(o_dac_load), .o_dac_data(o_dac_data));
   seq_ctrl_props u_seq_ctrl_props (.i_clk(i_clk), .i_nrst(i_nrst), .word_valid(u_seq_ctrl_if.word_valid),
      .word(u_seq_ctrl_if.word), .i_converting(i_converting), .o_channel_list(o_channel_list),
      .o_temp_sample(o_temp_sample), .o_loop_sequence(o_loop_sequence), .o_buffer_power(o_buffer_power),
      .o_input_span(o_input_span), .o_output_span(o_output_span), .o_pin_setup_freeze(o_pin_setup_freeze),
      .o_adc_pins(o_adc_pins), .o_dac_pins(o_dac_pins), .o_dac_load(o_dac_load), .o_dac_data(o_dac_data));
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   function automatic logic [7:0] exp_load(input logic [15:0] x);
      return x[15] ? (e_gen[6] ? e_dac : 8'h01 << x[14:12]) : 8'h00;
   endfunction : exp_load
   function automatic logic [15:0] legal_word(input logic [15:0] x);
      logic [15:0] y;
      y = x;
      if (x[15:11] == 5'h02 || x[15:11] == 5'h03) y[10] = 1'b0;
      if (x[15:11] == 5'h03) y[3:0] = 4'h0;
      return y;
   endfunction : legal_word
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   // Leading edge keeps the release and the next request in separate steps
   task automatic xfer(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] r);
      int   n;
      logic done;
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= d;
      n = 0;
      done = 1'b0;
      r = 32'h0;
      // Look between edges, where waitrequest and readdata are settled
      while (!done && n < 20)
      begin
         @(negedge i_clk);
         done = (o_avs_waitrequest === 1'b0);
         r = o_avs_readdata;
         @(posedge i_clk);
         n++;
      end
      if (!done) mismatches++;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask : xfer
   task automatic send(input logic [15:0] x);
      logic [31:0] r;
      xfer(1'b1, seq_ctrl_pkg::HOFS_CMD, {rnd, x}, r);
      if (x[15:11] == 5'h04 && !e_gen[7]) e_adc = x[7:0];
      if (x[15:11] == 5'h05 && !e_gen[7]) e_dac = x[7:0];
      if (x[15:11] == 5'h02) e_ord = x[10:0];
      if (x[15:11] == 5'h03) e_gen = x[10:0];
      @(posedge i_clk);
      @(negedge i_clk);
      chk({o_loop_sequence, o_temp_sample, o_channel_list}, e_ord[9:0]);
      chk({o_pin_setup_freeze, o_input_span, o_output_span}, {e_gen[7], e_gen[5:4]});
      chk({o_adc_pins, o_dac_pins}, {e_adc, e_dac});
      chk(o_dac_load, exp_load(x));
      if (x[15]) chk(o_dac_data, x[11:0]);
      // Buffer power settles one edge after the general register
      @(negedge i_clk);
      chk(o_buffer_power, e_gen[8] & (!e_gen[9] | i_converting));
      xfer(1'b0, seq_ctrl_pkg::HOFS_CMD, 32'h0, r);
      chk(r, {16'h0, legal_word(x)});
   endtask : send
   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      {e_ord, e_gen, e_adc, e_dac} = '0;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      chk({o_channel_list, o_temp_sample, o_loop_sequence, o_buffer_power, o_dac_load}, 0);
      chk(o_avs_waitrequest, 1);
      @(posedge i_clk);
      i_nrst <= 1'b1;
      $display("reset test done");
      xfer(1'b1, 2'h3, 32'hffff, q);
      xfer(1'b0, 2'h3, 32'h0, q);
      chk(q, 0);
      send(16'h17ff);
      send(16'h1fff);
      send(16'h13ff);
      send(16'h1bf0);
      send(16'h20a5);
      send(16'hc123);
      $display("corner test done");
      repeat (80)
      begin
         rnd = lfsr(rnd);
         w = lfsr(rnd);
         i_converting <= rnd[5];
         case (rnd[3:1])
            3'h0: w[15:10] = 6'h04;
            3'h1: {w[15:10], w[3:0]} = 10'h180;
            3'h2: w[15:8] = 8'h20;
            3'h3: w[15:8] = 8'h28;
            3'h4, 3'h5: w[15] = 1'b1;
            default: w[15:11] = rnd[4] ? 5'h0f : 5'h00;
         endcase
         send(w);
      end
      xfer(1'b0, seq_ctrl_pkg::HOFS_LAST, 32'h0, q);
      chk(q, {16'h0, legal_word(w)});
      $display("random test done");
      // Second reset mid-run must drop everything written so far
      @(posedge i_clk);
      i_nrst <= 1'b0;
      @(negedge i_clk);
      chk({o_channel_list, o_temp_sample, o_loop_sequence, o_buffer_power, o_adc_pins}, 0);
      chk({o_input_span, o_output_span, o_pin_setup_freeze, o_dac_pins, o_dac_data}, 0);
      @(posedge i_clk);
      i_nrst <= 1'b1;
      {e_ord, e_gen, e_adc, e_dac} = '0;
      send(16'h2855);
      $display("second reset test done");
      wrap_up();
   end
   initial
   begin
      repeat (5000) @(posedge i_clk);
      mismatches++;
      wrap_up();
   end
endmodule : tb_top
